// >>> rtl/dbgcs_map.vh
// register offsets, field positions, reset values and state codes of the debug comparator sequencer
`ifndef DBGCS_MAP_VH
`define DBGCS_MAP_VH
`define DBGCS_OFF_CTL1    8'h00
`define DBGCS_OFF_STAT    8'h04
`define DBGCS_OFF_CWIN    8'h08
`define DBGCS_OFF_ADDRA   8'h0C
`define DBGCS_OFF_ADDRB   8'h10
`define DBGCS_OFF_ADDRC   8'h14
`define DBGCS_OFF_SEQC    8'h18
`define DBGCS_OFF_TRC     8'h1C
`define DBGCS_C1_ARM      7
`define DBGCS_C1_FORCE_TRIGGER     6
`define DBGCS_C1_SEL_HI   1
`define DBGCS_C1_SEL_LO   0
`define DBGCS_CC_SZE      7
`define DBGCS_CC_SZ       6
`define DBGCS_CC_TAG      5
`define DBGCS_CC_BRK      4
`define DBGCS_CC_RW       3
`define DBGCS_CC_RWE      2
`define DBGCS_CC_COMPARATOR_ENABLE    0
`define DBGCS_CC_MASK_AB  8'hFD
`define DBGCS_CC_MASK_C   8'h3D
`define DBGCS_TRC_TSRC    0
`define DBGCS_RST_CTL     8'h00
`define DBGCS_RST_SEQC    6'h00
`define DBGCS_RST_TRC     1'b0
`define DBGCS_SEL_A       2'b00
`define DBGCS_SEL_B       2'b01
`define DBGCS_SEL_C       2'b10
`define DBGCS_ST_DISARM   3'b000
`define DBGCS_ST_ONE      3'b001
`define DBGCS_ST_FINAL    3'b100
`define DBGCS_NEXT_FINAL  2'b00
`define DBGCS_RESP_OKAY   2'b00
`define DBGCS_RESP_SLVERR 2'b10
`endif

// >>> rtl/dbgcs_top.v
// debug comparator channels, priority resolver, state sequencer and AXI4-Lite register slave
// Behaviour
// - window reads return channel A, B or C control for select 00, 01, 10.
// - window writes update the selected channel only while not armed.
// - direction enable 0 matches both; else direction bit 0 writes, 1 reads.
// - only channels A and B have size qualification; C has address and direction.
// - tagged hit moves sequencer only when the tagged opcode reaches execution.
// - while tagging, ignore direction and size; compare exact opcode address.
// - untagged match fires when the address appears on the system bus.
// - after a match, later matches do not recheck the original condition.
// - match outputs 0, 1, 2 come registered from channels A, B, C, and only while in states 1 to 3.
// - address match is exact equality, optionally qualified by direction and size.
// - channel C ignores a word access starting one below its address.
// - with size compare on, only the selected width matches.
// - force trigger and arm in one write trigger at once, whatever arm was.
// - priority: force, channel to final, then match 0, 1, 2; others dropped.
// - setting arm moves the sequencer from disarmed into state 1.
// - states 1 to 3 move freely; final may only go to disarmed.
// - every transition updates the three-bit state flags in status.
// - writing force trigger together with arm triggers at once, independent of matches.
// - channels with breakpoint-on-match request a breakpoint, bypassing the sequencer.
// - a session end passes final for one cycle then disarms.
// - trace source off: final entry only requests a breakpoint; arm clears.
`timescale 1ns/1ps
`include "dbgcs_map.vh"
module dbgcs_top #(
   parameter AW = 16
) (
   input  wire          aclk,
   input  wire          aresetn,
   input  wire [7:0]    s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output wire          s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output wire          s_axi_wready,
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   input  wire [7:0]    s_axi_araddr,
   input  wire          s_axi_arvalid,
   output wire          s_axi_arready,
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready,
   input  wire [AW-1:0] bus_addr,
   input  wire          bus_valid,
   input  wire          bus_read,
   input  wire          bus_byte,
   input  wire [AW-1:0] exec_addr,
   input  wire          exec_valid,
   output reg  [2:0]    match_out,
   output reg           brk_req,
   output reg           trace_force_trigger,
   output wire          armed
);

   localparam NCH = 3;

   // bus slave state
   reg            aw_have_r;
   reg  [7:0]     aw_addr_r;
   reg            w_have_r;
   reg  [31:0]    w_data_r;
   reg  [3:0]     w_strb_r;
   // registers
   reg            arm_r;
   reg  [1:0]     sel_r;
   reg  [7:0]     ctl_r [0:NCH-1];
   reg  [AW-1:0]  addr_r [0:NCH-1];
   reg  [5:0]     seqc_r;
   reg            tsrc_r;
   reg  [2:0]     state_r;
   reg  [2:0]     seen_r;
   reg  [2:0]     state_nxt;
   reg            arm_nxt;

   wire           wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;
   wire           wr_ctl1 = wr_fire & (aw_addr_r == `DBGCS_OFF_CTL1) & w_strb_r[0];
   wire           wr_arm  = wr_ctl1 & w_data_r[`DBGCS_C1_ARM];
   wire           wr_force_trigger = wr_ctl1 & w_data_r[`DBGCS_C1_FORCE_TRIGGER];
   wire           wr_ok;
   wire [2:0]     hit;
   wire [NCH-1:0] to_final;
   wire [NCH-1:0] seq_hit;

   assign s_axi_awready = ~aw_have_r;
   assign s_axi_wready  = ~w_have_r;
   assign s_axi_arready = ~s_axi_rvalid;
   assign armed         = arm_r;
   assign wr_ok = (aw_addr_r <= `DBGCS_OFF_TRC) & (aw_addr_r[1:0] == 2'b00);

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  strb;
      integer      i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (strb[i])
               merge[i*8 +: 8] = nw[i*8 +: 8];
      end
   endfunction

   // comparator channels
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1)
      begin : ch
         wire [7:0] c      = ctl_r[g];
         wire       a_eq   = bus_valid & (bus_addr == addr_r[g]);
         wire       dir_ok = ~c[`DBGCS_CC_RWE] | (c[`DBGCS_CC_RW] == bus_read);
         wire       sz_ok;
         if (g < 2)
         begin : sz
            assign sz_ok = ~c[`DBGCS_CC_SZE] | (c[`DBGCS_CC_SZ] == bus_byte);
         end
         else
         begin : nsz
            assign sz_ok = 1'b1;
         end
         wire tag_hit = exec_valid & (exec_addr == addr_r[g]);
         assign hit[g] = c[`DBGCS_CC_COMPARATOR_ENABLE] &
                         (c[`DBGCS_CC_TAG] ? tag_hit : (a_eq & dir_ok & sz_ok));
         assign seq_hit[g]  = hit[g] & ~c[`DBGCS_CC_BRK];
         assign to_final[g] = seq_hit[g] & (seqc_r[2*g +: 2] == `DBGCS_NEXT_FINAL);
      end
   endgenerate

   // sequencer next state; one winner per cycle, lower sources dropped
   always @*
   begin
      state_nxt = state_r;
      arm_nxt   = arm_r;
      if (wr_ctl1 & ~w_data_r[`DBGCS_C1_ARM])
      begin
         arm_nxt   = 1'b0;
         state_nxt = `DBGCS_ST_DISARM;
      end
      else if (wr_force_trigger & (wr_arm | arm_r))
      begin
         arm_nxt   = 1'b1;
         state_nxt = `DBGCS_ST_FINAL;
      end
      else if (state_r == `DBGCS_ST_FINAL)
      begin
         arm_nxt   = 1'b0;
         state_nxt = `DBGCS_ST_DISARM;
      end
      else if (state_r == `DBGCS_ST_DISARM)
      begin
         if (wr_arm)
         begin
            arm_nxt   = 1'b1;
            state_nxt = `DBGCS_ST_ONE;
         end
      end
      else if (|to_final)
         state_nxt = `DBGCS_ST_FINAL;
      else if (seq_hit[0])
         state_nxt = {1'b0, seqc_r[1:0]};
      else if (seq_hit[1])
         state_nxt = {1'b0, seqc_r[3:2]};
      else if (seq_hit[2])
         state_nxt = {1'b0, seqc_r[5:4]};
   end

   wire active   = (state_r != `DBGCS_ST_DISARM) & (state_r != `DBGCS_ST_FINAL);
   wire enter_fn = (state_nxt == `DBGCS_ST_FINAL) & (state_r != `DBGCS_ST_FINAL);
   wire [2:0] brk_hit;
   generate
      for (g = 0; g < NCH; g = g + 1)
      begin : bk
         assign brk_hit[g] = active & hit[g] & ctl_r[g][`DBGCS_CC_BRK];
      end
   endgenerate

   // sequencer, outputs and match memory
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_r    <= `DBGCS_ST_DISARM;
         arm_r      <= 1'b0;
         match_out  <= 3'b000;
         brk_req    <= 1'b0;
         trace_force_trigger <= 1'b0;
         seen_r     <= 3'b000;
      end
      else
      begin
         state_r    <= state_nxt;
         arm_r      <= arm_nxt;
         match_out  <= active ? hit : 3'b000;
         // pulse only: each request lasts one clock even if the hit persists
         brk_req    <= ((|brk_hit) | (enter_fn & ~tsrc_r)) & ~brk_req;
         trace_force_trigger <= enter_fn & tsrc_r;
         // once matched, a channel stays recorded; no later re-qualification
         if (wr_arm & (state_r == `DBGCS_ST_DISARM))
            seen_r <= 3'b000;
         else
            seen_r <= seen_r | (active ? hit : 3'b000);
      end
   end

   // register writes
   wire [31:0] addr_mrg0 = merge({{(32-AW){1'b0}}, addr_r[0]}, w_data_r, w_strb_r);
   wire [31:0] addr_mrg1 = merge({{(32-AW){1'b0}}, addr_r[1]}, w_data_r, w_strb_r);
   wire [31:0] addr_mrg2 = merge({{(32-AW){1'b0}}, addr_r[2]}, w_data_r, w_strb_r);
   integer k;
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sel_r  <= 2'b00;
         seqc_r <= `DBGCS_RST_SEQC;
         tsrc_r <= `DBGCS_RST_TRC;
         for (k = 0; k < NCH; k = k + 1)
         begin
            ctl_r[k]  <= `DBGCS_RST_CTL;
            addr_r[k] <= {AW{1'b0}};
         end
      end
      else if (wr_fire)
      begin
         case (aw_addr_r)
            `DBGCS_OFF_CTL1:
               if (w_strb_r[0])
                  sel_r <= w_data_r[`DBGCS_C1_SEL_HI:`DBGCS_C1_SEL_LO];
            `DBGCS_OFF_CWIN:
               // armed window writes are dropped so a running session keeps its channel controls; address and sequencer writes still land
               if (w_strb_r[0] & ~arm_r)
               begin
                  case (sel_r)
                     `DBGCS_SEL_A: ctl_r[0] <= w_data_r[7:0] & `DBGCS_CC_MASK_AB;
                     `DBGCS_SEL_B: ctl_r[1] <= w_data_r[7:0] & `DBGCS_CC_MASK_AB;
                     `DBGCS_SEL_C: ctl_r[2] <= w_data_r[7:0] & `DBGCS_CC_MASK_C;
                     default:      ctl_r[0] <= ctl_r[0];
                  endcase
               end
            `DBGCS_OFF_ADDRA:
               addr_r[0] <= addr_mrg0[AW-1:0];
            `DBGCS_OFF_ADDRB:
               addr_r[1] <= addr_mrg1[AW-1:0];
            `DBGCS_OFF_ADDRC:
               addr_r[2] <= addr_mrg2[AW-1:0];
            `DBGCS_OFF_SEQC:
               if (w_strb_r[0])
                  seqc_r <= w_data_r[5:0];
            `DBGCS_OFF_TRC:
               if (w_strb_r[0])
                  tsrc_r <= w_data_r[`DBGCS_TRC_TSRC];
            default:
               tsrc_r <= tsrc_r;
         endcase
      end
   end

   // read mux
   reg [31:0] rd_val;
   reg        rd_ok;
   always @*
   begin
      rd_val = 32'h0000_0000;
      rd_ok  = 1'b1;
      case (s_axi_araddr)
         `DBGCS_OFF_CTL1:  rd_val = {24'h000000, arm_r, 5'h00, sel_r};
         `DBGCS_OFF_STAT:  rd_val = {25'h0, seen_r, 1'b0, state_r};
         `DBGCS_OFF_CWIN:
            case (sel_r)
               `DBGCS_SEL_A: rd_val = {24'h000000, ctl_r[0]};
               `DBGCS_SEL_B: rd_val = {24'h000000, ctl_r[1]};
               `DBGCS_SEL_C: rd_val = {24'h000000, ctl_r[2]};
               default:      rd_val = 32'h0000_0000;
            endcase
         `DBGCS_OFF_ADDRA: rd_val = {{(32-AW){1'b0}}, addr_r[0]};
         `DBGCS_OFF_ADDRB: rd_val = {{(32-AW){1'b0}}, addr_r[1]};
         `DBGCS_OFF_ADDRC: rd_val = {{(32-AW){1'b0}}, addr_r[2]};
         `DBGCS_OFF_SEQC:  rd_val = {26'h0, seqc_r};
         `DBGCS_OFF_TRC:   rd_val = {31'h0, tsrc_r};
         default:          rd_ok  = 1'b0;
      endcase
   end

   // AXI4-Lite handshakes
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_r    <= 1'b0;
         aw_addr_r    <= 8'h00;
         w_have_r     <= 1'b0;
         w_data_r     <= 32'h0000_0000;
         w_strb_r     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `DBGCS_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `DBGCS_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid & ~aw_have_r)
         begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid & ~w_have_r)
         begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `DBGCS_RESP_OKAY : `DBGCS_RESP_SLVERR;
         end
         else if (s_axi_bvalid & s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
         end
         if (s_axi_arvalid & ~s_axi_rvalid)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? `DBGCS_RESP_OKAY : `DBGCS_RESP_SLVERR;
         end
         else if (s_axi_rvalid & s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// >>> testbench/dbgcs_top_monitor.sv
// port checker for the debug comparator sequencer
`timescale 1ns/1ps
module dbgcs_top_monitor (
   input wire       aclk,
   input wire       aresetn,
   input wire       s_axi_awvalid,
   input wire       s_axi_awready,
   input wire       s_axi_wvalid,
   input wire       s_axi_wready,
   input wire       s_axi_bvalid,
   input wire       s_axi_arvalid,
   input wire       s_axi_arready,
   input wire       s_axi_rvalid,
   input wire       bus_valid,
   input wire       exec_valid,
   input wire [2:0] match_out,
   input wire       brk_req,
   input wire       trace_force_trigger,
   input wire       armed
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   chk_brk_pulse: assert property (brk_req |=> !brk_req)
      else $error("breakpoint request wider than one cycle");
   chk_force_trigger_pulse: assert property (trace_force_trigger |=> !trace_force_trigger)
      else $error("trace trigger wider than one cycle");
   chk_final_disarm: assert property (trace_force_trigger |-> ##[0:2] !armed)
      else $error("module still armed after final state");
   chk_match_armed: assert property (|match_out |-> $past(armed))
      else $error("match reported while disarmed");
   chk_match_cause: assert property (|match_out |-> $past(bus_valid || exec_valid))
      else $error("match without a bus or execute cycle");
   chk_reset_idle: assert property (disable iff (1'b0) !aresetn |=> !armed && !brk_req && !trace_force_trigger)
      else $error("outputs not idle after reset");
   chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid)
      else $error("write answer late");
endmodule
bind dbgcs_top dbgcs_top_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .bus_valid, .exec_valid,
   .match_out, .brk_req, .trace_force_trigger, .armed);

// >>> testbench/dbgcs_cpu_model.sv
// cpu side model: bus cycles and executed opcode addresses
`timescale 1ns/1ps
module dbgcs_cpu_model #(
   parameter AW = 16
) (
   input  wire            aclk,
   output logic [AW-1:0]  bus_addr,
   output logic           bus_valid,
   output logic           bus_read,
   output logic           bus_byte,
   output logic [AW-1:0]  exec_addr,
   output logic           exec_valid
);
   initial
   begin
      {bus_addr, bus_valid, bus_read, bus_byte, exec_addr, exec_valid} = '0;
   end
   // one cycle per call; released lines show the inverse so stale values never match
   task acc(input logic [AW-1:0] a, input logic rd, input logic by, input logic ex);
      if (ex)
      begin
         exec_addr <= a;
         exec_valid <= 1'b1;
      end
      else
      begin
         bus_addr <= a;
         bus_valid <= 1'b1;
         bus_read <= rd;
         bus_byte <= by;
      end
      @(posedge aclk);
      {bus_valid, exec_valid} <= 2'b00;
      bus_addr <= ~a;
      exec_addr <= ~a;
      bus_read <= ~rd;
      bus_byte <= ~by;
   endtask
endmodule

// >>> testbench/tb_dbgcs_top.sv
// self-checking bench for the debug comparator sequencer
`timescale 1ns/1ps
module tb_dbgcs_top;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   // answer readies stay high, so back-to-back transfers never drive them twice in one step
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire  [15:0] bus_addr, exec_addr;
   wire         bus_valid, bus_read, bus_byte, exec_valid, brk_req, trace_force_trigger, armed;
   wire  [2:0]  match_out;
   logic [2:0]  m_acc;
   logic [1:0]  rr;
   int          err_total = 0, n_checks = 0, n_brk, n_trg;
   dbgcs_top #(.AW(16)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus_addr,
      .bus_valid, .bus_read, .bus_byte, .exec_addr, .exec_valid, .match_out, .brk_req, .trace_force_trigger, .armed);
   dbgcs_cpu_model #(.AW(16)) u_cpu (.aclk, .bus_addr, .bus_valid, .bus_read, .bus_byte, .exec_addr, .exec_valid);
   initial forever #5 aclk = ~aclk;
   // sampled mid-cycle, so clearing the tallies just after an edge never races them
   always @(negedge aclk)
   begin
      if (brk_req === 1'b1) n_brk++;
      if (trace_force_trigger === 1'b1) n_trg++;
      m_acc = m_acc | match_out;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task hang;
      err_total++;
      stop_test;
   endtask
   task clr;
      n_brk = 0;
      n_trg = 0;
      m_acc = 3'b000;
   endtask
   task rst;
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      clr;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int k;
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
      k = 0;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         k++;
      end
      while (s_axi_bvalid !== 1'b1 && k < 40);
      if (k >= 40) hang;
      check(s_axi_bresp, er);
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d);
      int k;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      k = 0;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         k++;
      end
      while (s_axi_rvalid !== 1'b1 && k < 40);
      {d, rr} = {s_axi_rdata, s_axi_rresp};
      if (k >= 40) hang;
   endtask
   task t_reset;
      logic [31:0] d;
      rst;
      check({armed, brk_req, trace_force_trigger, match_out}, 6'h00);
      rd(8'h08, d);
      check(d, 32'h0);
      rd(8'h40, d);
      check(d, 32'h0);
      check(rr, 2'h2);
      wr(8'h40, 32'hFF, 2'h2);
      $display("reset test done");
   endtask
   task automatic t_window;
      logic [31:0] d;
      logic [7:0]  v [3] = '{8'hF1, 8'hE5, 8'hFF};
      logic [7:0]  e [3] = '{8'hF1, 8'hE5, 8'h3D};
      rst;
      for (int i = 0; i < 3; i++)
      begin
         wr(8'h00, i, 2'h0);
         wr(8'h08, v[i], 2'h0);
      end
      for (int i = 0; i < 3; i++)
      begin
         wr(8'h00, i, 2'h0);
         rd(8'h08, d);
         check(d, e[i]);
      end
      wr(8'h00, 32'h80, 2'h0);
      wr(8'h08, 32'h00, 2'h0);
      rd(8'h08, d);
      check(d, 32'hF1);
      rd(8'h04, d);
      check(d[2:0], 3'h1);
      $display("window test done");
   endtask
   task automatic t_dir;
      logic [31:0] d;
      logic [15:0] ad [5] = '{16'h1234, 16'h1233, 16'h1234, 16'h2000, 16'h2000};
      logic [2:0]  ex [5] = '{3'h0, 3'h0, 3'h4, 3'h0, 3'h2};
      logic [4:0]  rdv = 5'b11110;
      logic [4:0]  byv = 5'b10101;
      rst;
      wr(8'h00, 32'h1, 2'h0);
      wr(8'h08, 32'hC1, 2'h0);
      wr(8'h10, 32'h2000, 2'h0);
      wr(8'h00, 32'h2, 2'h0);
      wr(8'h08, 32'h0D, 2'h0);
      wr(8'h14, 32'h1234, 2'h0);
      wr(8'h18, 32'h2A, 2'h0);
      wr(8'h00, 32'h80, 2'h0);
      for (int i = 0; i < 5; i++)
      begin
         clr;
         u_cpu.acc(ad[i], rdv[i], byv[i], 1'b0);
         repeat (2) @(posedge aclk);
         check(m_acc, ex[i]);
      end
      rd(8'h04, d);
      check(d[6:0], 7'h62);
      $display("direction and size test done");
   endtask
   task t_tag;
      rst;
      wr(8'h08, 32'h25, 2'h0);
      wr(8'h0C, 32'h3001, 2'h0);
      wr(8'h18, 32'h2, 2'h0);
      wr(8'h00, 32'h80, 2'h0);
      u_cpu.acc(16'h3001, 1'b0, 1'b0, 1'b0);
      repeat (2) @(posedge aclk);
      check(m_acc, 3'h0);
      u_cpu.acc(16'h3001, 1'b1, 1'b0, 1'b1);
      repeat (2) @(posedge aclk);
      check(m_acc, 3'h1);
      $display("tag test done");
   endtask
   task t_force;
      rst;
      wr(8'h00, 32'hC0, 2'h0);
      repeat (4) @(posedge aclk);
      check(n_brk, 32'd1);
      check(n_trg, 32'd0);
      check(armed, 1'b0);
      wr(8'h1C, 32'h1, 2'h0);
      wr(8'h00, 32'h80, 2'h0);
      clr;
      wr(8'h00, 32'hC0, 2'h0);
      repeat (4) @(posedge aclk);
      check(n_brk, 32'd0);
      check(n_trg, 32'd1);
      check(armed, 1'b0);
      $display("force test done");
   endtask
   task t_final;
      logic [31:0] d;
      rst;
      wr(8'h08, 32'h01, 2'h0);
      wr(8'h0C, 32'h4000, 2'h0);
      wr(8'h00, 32'h1, 2'h0);
      wr(8'h08, 32'h01, 2'h0);
      wr(8'h10, 32'h4000, 2'h0);
      wr(8'h00, 32'h2, 2'h0);
      wr(8'h08, 32'h11, 2'h0);
      wr(8'h14, 32'h5000, 2'h0);
      wr(8'h18, 32'h32, 2'h0);
      wr(8'h00, 32'h80, 2'h0);
      clr;
      u_cpu.acc(16'h5000, 1'b1, 1'b0, 1'b0);
      repeat (3) @(posedge aclk);
      rd(8'h04, d);
      check(n_brk, 32'd1);
      check(armed, 1'b1);
      check(d[2:0], 3'h1);
      clr;
      u_cpu.acc(16'h4000, 1'b1, 1'b0, 1'b0);
      repeat (4) @(posedge aclk);
      rd(8'h04, d);
      check(n_brk, 32'd1);
      check(armed, 1'b0);
      check(d[2:0], 3'h0);
      check(m_acc, 3'h3);
      $display("final state test done");
   endtask
   initial
   begin
      t_reset;
      t_window;
      t_dir;
      t_tag;
      t_force;
      t_final;
      stop_test;
   end
endmodule
